// >>> bnv_pkg.sv
// Purpose: Shared constants and types for the byte store block
// Assumes: 100 MHz aclk; latencies are counted at the 20 MHz reference rate
// Notes: Cycle counts follow the reference rate, so a slower clock stretches time
package bnv_pkg;
  // ----------------------------------------------------------------
  // Store geometry
  // ----------------------------------------------------------------
  localparam int STORE_SIZE = 100;
  localparam int IDX_W = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] MAINT_PERIOD = 8'hC8;

  // ----------------------------------------------------------------
  // Timing, in ns at the reference clock
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS = 50;
  localparam int T_WRITE_NS = 136000;
  localparam int T_MAINT_NS = 58000000;
  localparam int T_BAD_WR_NS = 7000;
  localparam int T_BAD_RD_NS = 6000;
  localparam int T_RD_MIN_NS = 71000;
  localparam int T_RD_MAX_NS = 258000;
  localparam int T_RD_STEP_NS = 800;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] CYC_WRITE = TMR_W'(T_WRITE_NS / REF_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_BAD_WR = TMR_W'(T_BAD_WR_NS / REF_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_BAD_RD = TMR_W'(T_BAD_RD_NS / REF_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_RD_MIN = TMR_W'(T_RD_MIN_NS / REF_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_RD_STEP = TMR_W'(T_RD_STEP_NS / REF_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_ARG_ADDR = 8'h00;
  localparam logic [AXI_AW-1:0] REG_ARG_DATA = 8'h04;
  localparam logic [AXI_AW-1:0] REG_CALL = 8'h08;
  localparam logic [AXI_AW-1:0] REG_RESULT = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_STATE = 8'h10;
  localparam logic [AXI_AW-1:0] REG_WEAR = 8'h14;
  localparam int CALL_WRITE = 0;
  localparam int CALL_READ = 1;
  localparam int ST_WRITE_ERR = 0;
  localparam int ST_BAD_ADDR = 1;
  localparam int ST_FLASH_FAULT = 2;
  localparam int ST_CORRUPT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation in progress
  typedef enum logic [1:0] {BNV_IDLE, BNV_WRITE, BNV_READ} bnv_op_t;
endpackage

// >>> bnv_regbus_if.sv
// Purpose: Simple register strobes between the bus slave and the store core
// Assumes: One write strobe per cycle; read data is combinational
// Notes: Errors flag unmapped offsets
interface bnv_regbus_if;
  import bnv_pkg::*;
  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_err, rd_data, rd_err);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// >>> bnv_timer.sv
// Purpose: Countdown timer that paces each store operation
// Assumes: Load only while idle
// Notes: done is a one-cycle pulse when the count runs out
module bnv_timer
  import bnv_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic load,
  input wire logic [TMR_W-1:0] value,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic busy;
    logic done;
  } bnv_tmr_t;
  bnv_tmr_t st, next_st;

  // Count down to one, then pulse done
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (load) begin
      next_st.count = value;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (st.count <= TMR_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count - TMR_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
endmodule

// >>> bnv_axil.sv
// Purpose: AXI4-Lite slave turning bus traffic into register strobes
// Assumes: Address and data may arrive in either order
// Notes: One write and one read outstanding at most
module bnv_axil
  import bnv_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read channels
  input wire logic [AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Register side
  bnv_regbus_if.bus rb
);
  typedef struct packed {
    logic aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bnv_axi_t;
  bnv_axi_t st, next_st;

  // Handshake outputs
  assign s_axil_awready = !st.aw_full && !st.bvalid;
  assign s_axil_wready = !st.w_full && !st.bvalid;
  assign s_axil_arready = !st.rvalid;
  assign rb.wr_en = st.aw_full && st.w_full && !st.bvalid;
  assign rb.wr_addr = st.aw_addr;
  assign rb.wr_data = st.w_data;
  assign rb.wr_strb = st.w_strb;
  assign rb.rd_addr = s_axil_araddr;

  // Channel capture and responses
  always_comb begin
    next_st = st;
    if (s_axil_awvalid && s_axil_awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axil_wdata;
      next_st.w_strb = s_axil_wstrb;
    end
    if (rb.wr_en) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = rb.wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (st.bvalid && s_axil_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rb.rd_data;
      next_st.rresp = rb.rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (st.rvalid && s_axil_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axil_bvalid = st.bvalid;
  assign s_axil_bresp = st.bresp;
  assign s_axil_rvalid = st.rvalid;
  assign s_axil_rdata = st.rdata;
  assign s_axil_rresp = st.rresp;
endmodule

// >>> bnv_byte_nv_store.sv
// Purpose: Byte non-volatile store with call-style write and read operations
// Assumes: Software reaches it over AXI4-Lite; flash_fault comes from the array
// Notes: Store contents survive aresetn; only control state is reset
//
// Notes on behaviour
// - Address and data are single bytes
// - Caller working registers kept until return
// - Normal write lasts 136 us at reference
// - Every 200th write runs long maintenance
// - Bad write address: no change, 7 us
// - Read back stored byte, flag mismatch
// - Flash fault flagged; reserved bits zero
// - Read returns data and status registers
// - Bad read address returns FF in 6 us
// - Valid read lasts 71 to 258 us
// - Corrupt latest copy returns last good value
// - Faulty newest entry sets corrupt, steps older
// - Read status bits 4, 2, 1 only
// - Power loss endangers only byte being written
// - Reset mid-write spares all other bytes
// - Read slows 0.8 us per foreign write
// - Store holds 100 bytes
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
module bnv_byte_nv_store
  import bnv_pkg::*;
#(
  parameter logic [TMR_W-1:0] MAINT_CYCLES = TMR_W'(T_MAINT_NS / REF_PERIOD_NS),
  parameter logic [TMR_W-1:0] RD_MAX_CYCLES = TMR_W'(T_RD_MAX_NS / REF_PERIOD_NS)
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read channels
  input wire logic [AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Flash array health
  input wire logic flash_fault
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bnv_op_t op;
    logic op_bad;
    logic [7:0] op_addr;
    logic [7:0] op_data;
    logic [7:0] arg_addr;
    logic [7:0] arg_data;
    logic [7:0] working_reg_zero;
    logic [7:0] working_reg_one;
    logic fault;
    logic [7:0] erase_cnt;
    logic [7:0] last_status;
  } bnv_ctl_t;

  typedef struct packed {
    logic [STORE_SIZE-1:0][7:0] latest;
    logic [STORE_SIZE-1:0][7:0] backup;
    logic [STORE_SIZE-1:0][7:0] stamp;
    logic [STORE_SIZE-1:0] pending;
    logic [STORE_SIZE-1:0] backup_ok;
    logic [31:0] wear;
  } bnv_mem_t;

  typedef struct packed {
    bnv_ctl_t ctl;
    bnv_mem_t mem;
  } bnv_state_t;

  bnv_state_t st, next_st;
  bnv_regbus_if rb ();
  // Pacing timer hand-off
  logic tmr_load;
  logic [TMR_W-1:0] tmr_value;
  logic tmr_busy;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address falls inside the store
  function automatic logic in_store(input logic [7:0] a);
    in_store = (a < 8'(STORE_SIZE));
  endfunction

  // Store index from a checked address
  function automatic logic [IDX_W-1:0] idx(input logic [7:0] a);
    idx = a[IDX_W-1:0];
  endfunction

  // Read pacing grows with writes to other addresses, capped
  function automatic logic [TMR_W-1:0] rd_latency(input logic [7:0] extra);
    logic [TMR_W-1:0] t;
    t = CYC_RD_MIN + TMR_W'(extra) * CYC_RD_STEP;
    // Cap keeps heavily aged reads at the slowest figure
    rd_latency = (t > RD_MAX_CYCLES) ? RD_MAX_CYCLES : t;
  endfunction

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  bnv_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .rb(rb.bus)
  );

  bnv_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load),
    .value(tmr_value),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Write side only checks the offset
  always_comb begin
    rb.wr_err = 1'b0;
    if (rb.wr_addr == REG_ARG_ADDR) begin
      rb.wr_err = 1'b0;
    end else if (rb.wr_addr == REG_ARG_DATA) begin
      rb.wr_err = 1'b0;
    end else if (rb.wr_addr == REG_CALL) begin
      rb.wr_err = 1'b0;
    end else if (rb.wr_addr == REG_RESULT) begin
      // Read-only offsets accept writes and ignore them
      rb.wr_err = 1'b0;
    end else if (rb.wr_addr == REG_STATE) begin
      rb.wr_err = 1'b0;
    end else if (rb.wr_addr == REG_WEAR) begin
      rb.wr_err = 1'b0;
    end else begin
      rb.wr_err = 1'b1;
    end
  end

  // Read data mux
  always_comb begin
    rb.rd_data = 32'h0;
    rb.rd_err = 1'b0;
    if (rb.rd_addr == REG_ARG_ADDR) begin
      rb.rd_data = {24'h0, st.ctl.arg_addr};
    end else if (rb.rd_addr == REG_ARG_DATA) begin
      rb.rd_data = {24'h0, st.ctl.arg_data};
    end else if (rb.rd_addr == REG_CALL) begin
      rb.rd_data = 32'h0;
    end else if (rb.rd_addr == REG_RESULT) begin
      rb.rd_data = {16'h0, st.ctl.working_reg_one, st.ctl.working_reg_zero};
    end else if (rb.rd_addr == REG_STATE) begin
      rb.rd_data = {8'h0, st.ctl.last_status, st.ctl.erase_cnt, 7'h0, tmr_busy};
    end else if (rb.rd_addr == REG_WEAR) begin
      rb.rd_data = st.mem.wear;
    end else begin
      rb.rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [IDX_W-1:0] a;
    logic [7:0] status;
    logic call;
    a = '0;
    status = 8'h0;
    call = 1'b0;
    next_st = st;
    tmr_load = 1'b0;
    tmr_value = '0;

    // Argument bytes and call strobe
    if (rb.wr_en && rb.wr_strb[0]) begin
      if (rb.wr_addr == REG_ARG_ADDR) begin
        next_st.ctl.arg_addr = rb.wr_data[7:0];
      end else if (rb.wr_addr == REG_ARG_DATA) begin
        next_st.ctl.arg_data = rb.wr_data[7:0];
      end else if (rb.wr_addr == REG_CALL) begin
        call = (st.ctl.op == BNV_IDLE);
      end
    end

    // Flash faults seen while an operation runs are kept
    if (st.ctl.op != BNV_IDLE && flash_fault) begin
      next_st.ctl.fault = 1'b1;
    end

    // Idle tracks the arguments so a call sees the bytes in place
    case (st.ctl.op)
      BNV_IDLE: begin
        a = idx(st.ctl.arg_addr);
        next_st.ctl.op_addr = st.ctl.arg_addr;
        next_st.ctl.op_data = st.ctl.arg_data;
        next_st.ctl.op_bad = !in_store(st.ctl.arg_addr);
        next_st.ctl.fault = 1'b0;
        // Write wins when both call bits are set
        if (call && rb.wr_data[CALL_WRITE]) begin
          next_st.ctl.op = BNV_WRITE;
          tmr_load = 1'b1;
          if (!in_store(st.ctl.arg_addr)) begin
            tmr_value = CYC_BAD_WR;
          end else begin
            // Keep the older good copy before overwriting
            if (!st.mem.pending[a]) begin
              next_st.mem.backup[a] = st.mem.latest[a];
              next_st.mem.backup_ok[a] = 1'b1;
            end
            next_st.mem.latest[a] = st.ctl.arg_data;
            next_st.mem.pending[a] = 1'b1;
            // Wear counts every accepted valid write
            next_st.mem.wear = st.mem.wear + 32'h1;
            // The last write of a period pays for the page erase
            if (st.ctl.erase_cnt == MAINT_PERIOD - 8'h1) begin
              tmr_value = MAINT_CYCLES;
              next_st.ctl.erase_cnt = 8'h0;
              next_st.mem.stamp = '0;
            end else begin
              tmr_value = CYC_WRITE;
              next_st.ctl.erase_cnt = st.ctl.erase_cnt + 8'h1;
              next_st.mem.stamp[a] = st.ctl.erase_cnt + 8'h1;
            end
          end
        end else if (call && rb.wr_data[CALL_READ]) begin
          next_st.ctl.op = BNV_READ;
          tmr_load = 1'b1;
          if (!in_store(st.ctl.arg_addr)) begin
            tmr_value = CYC_BAD_RD;
          end else begin
            // Older stamps mean more entries to scan
            tmr_value = rd_latency(st.ctl.erase_cnt - st.mem.stamp[a]);
          end
        end
      end

      BNV_WRITE: begin
        a = idx(st.ctl.op_addr);
        if (tmr_done) begin
          status = 8'h0;
          if (st.ctl.op_bad) begin
            status[ST_BAD_ADDR] = 1'b1;
          end else begin
            // Read back what was stored
            if (st.mem.latest[a] != st.ctl.op_data) begin
              status[ST_WRITE_ERR] = 1'b1;
            end
            // Committed: the newest copy is now the good one
            next_st.mem.pending[a] = 1'b0;
          end
          status[ST_FLASH_FAULT] = st.ctl.fault || flash_fault;
          next_st.ctl.working_reg_zero = status;
          next_st.ctl.last_status = status;
          next_st.ctl.op = BNV_IDLE;
        end
      end

      BNV_READ: begin
        a = idx(st.ctl.op_addr);
        if (tmr_done) begin
          status = 8'h0;
          if (st.ctl.op_bad) begin
            next_st.ctl.working_reg_zero = ERASED_BYTE;
            status[ST_BAD_ADDR] = 1'b1;
          end else if (st.mem.pending[a]) begin
            // Newest copy unfinished: fall back to the older entry
            status[ST_CORRUPT] = 1'b1;
            next_st.ctl.working_reg_zero =
              st.mem.backup_ok[a] ? st.mem.backup[a] : ERASED_BYTE;
          end else begin
            next_st.ctl.working_reg_zero = st.mem.latest[a];
          end
          status[ST_FLASH_FAULT] = st.ctl.fault || flash_fault;
          next_st.ctl.working_reg_one = status;
          next_st.ctl.last_status = status;
          next_st.ctl.op = BNV_IDLE;
        end
      end

      // Unused encoding falls back to idle
      default: begin
        next_st.ctl.op = BNV_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset clears control only; the store array keeps committed bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // A cut write stays pending so the next read falls back
      st.ctl <= '0;
      st.mem <= st.mem;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> bnv_chk.sv
// Purpose: Bus-level checks on the byte store top module ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Attached to the store top module by bind at the foot of this file
module bnv_chk
  import bnv_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read channels
  input wire logic [AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic aw_bad;
  logic ar_bad;
  // Unmapped read offset: past the last register or not word aligned
  assign ar_bad = (s_axil_araddr > REG_WEAR) || (s_axil_araddr[1:0] != 2'h0);
  // Remember whether the accepted write offset was unmapped
  always_ff @(posedge aclk) begin
    if (!aresetn)
      aw_bad <= 1'b0;
    else if (s_axil_awvalid && s_axil_awready)
      aw_bad <= (s_axil_awaddr > REG_WEAR) || (s_axil_awaddr[1:0] != 2'h0);
  end
  // ----------------------------------------------------------------
  // Handshake steps and properties
  // ----------------------------------------------------------------
  sequence s_wr_taken;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence s_rd_taken;
    s_axil_arvalid && s_axil_arready;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##[1:2] s_axil_bvalid;
  endproperty
  property p_rd_answer;
    s_rd_taken |=> s_axil_rvalid;
  endproperty
  property p_b_hold;
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp);
  endproperty
  property p_r_hold;
    s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable({s_axil_rdata, s_axil_rresp});
  endproperty
  property p_wr_block;
    s_axil_bvalid |-> !s_axil_awready && !s_axil_wready;
  endproperty
  property p_r_done;
    s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid && s_axil_arready;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_axil_rresp == ($past(ar_bad) ? RESP_SLVERR : RESP_OKAY)
      && (!$past(ar_bad) || s_axil_rdata == 32'h0);
  endproperty
  property p_wr_resp;
    $rose(s_axil_bvalid) |-> s_axil_bresp == (aw_bad ? RESP_SLVERR : RESP_OKAY);
  endproperty
  property p_reset_idle;
    $rose(aresetn) |-> !s_axil_bvalid && !s_axil_rvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_wr_block: assert property (p_wr_block) else $error("write taken while answering");
  a_r_done: assert property (p_r_done) else $error("read answer not retired");
  a_rd_resp: assert property (p_rd_resp) else $error("read response code wrong");
  a_wr_resp: assert property (p_wr_resp) else $error("write response code wrong");
  a_reset_idle: assert property (p_reset_idle) else $error("answer pending after reset");
endmodule

bind bnv_byte_nv_store bnv_chk bnv_chk_i (.*);

// >>> bnv_cpu_model.sv
// Purpose: Caller side of the store, issuing calls over AXI4-Lite
// Assumes: The bench issues one call at a time
// Notes: No other traffic touches the store while a call is in flight
module bnv_cpu_model
  import bnv_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [AXI_AW-1:0] s_axil_awaddr,
  output logic s_axil_awvalid,
  input wire logic s_axil_awready,
  output logic [31:0] s_axil_wdata,
  output logic [3:0] s_axil_wstrb,
  output logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  output logic s_axil_bready,
  // Read channels
  output logic [AXI_AW-1:0] s_axil_araddr,
  output logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  output logic s_axil_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned now = 0;
  // Free-running cycle count for timing calls
  always @(posedge aclk) now <= now + 1;
  // Idle bus at time zero
  initial begin
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    s_axil_wstrb = 4'hF;
  end
  // One register write; each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  // One register read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
  // One store call: push arguments, call, wait out busy, fetch results
  task automatic op(input logic rd_op, input logic [7:0] a, d, output logic [7:0] r0, r1,
      output int unsigned cyc);
    logic [1:0] r;
    logic [31:0] v;
    int unsigned t0;
    wr(REG_ARG_ADDR, {24'h0, a}, r);
    if (!rd_op) wr(REG_ARG_DATA, {24'h0, d}, r);
    wr(REG_CALL, rd_op ? 32'h2 : 32'h1, r);
    t0 = now;
    do rd(REG_STATE, v, r); while (v[0] !== 1'b0);
    cyc = now - t0;
    rd(REG_RESULT, v, r);
    {r1, r0} = v[15:0];
  endtask
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the byte store block
// Assumes: Shortened maintenance and read cap parameters
// Notes: Timing windows allow for the slack of status polling
module tb
  import bnv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, flash_fault;
  logic [AXI_AW-1:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, v;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, resp;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [7:0] r0, r1;
  int unsigned cyc, ticks = 0, mismatches = 0, cmp_count = 0;
  bnv_byte_nv_store #(.MAINT_CYCLES(24'd50), .RD_MAX_CYCLES(24'd1500)) bnv_byte_nv_store_i (.*);
  bnv_cpu_model bnv_cpu_model_i (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tm(input int unsigned n);
    chk((cyc + 2 >= n && cyc <= n + 8) ? n : cyc, n);
  endtask
  task automatic go(input logic rd_op, input logic [7:0] a, d);
    bnv_cpu_model_i.op(rd_op, a, d, r0, r1, cyc);
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic zap();
    repeat (200) @(posedge aclk);
    flash_fault <= 1'b1;
    @(posedge aclk);
    flash_fault <= 1'b0;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map();
    bnv_cpu_model_i.rd(REG_RESULT, v, resp);
    chk(v, 32'h0);
    bnv_cpu_model_i.rd(REG_STATE, v, resp);
    chk(v, 32'h0);
    bnv_cpu_model_i.rd(8'h40, v, resp);
    chk(v, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    bnv_cpu_model_i.wr(8'h40, 32'h0, resp);
    chk(resp, RESP_SLVERR);
  endtask
  task automatic t_ops();
    go(1'b0, 8'h05, 8'hA5);
    chk(r0, 8'h00);
    tm(2720);
    go(1'b0, 8'h63, 8'h3C);
    chk(r0, 8'h00);
    bnv_cpu_model_i.rd(REG_STATE, v, resp);
    chk(v, 32'h00000200);
    go(1'b1, 8'h05, 8'h00);
    chk({r1, r0}, 16'h00A5);
    tm(1436);
  endtask
  task automatic t_bad();
    go(1'b0, 8'h64, 8'h77);
    chk(r0, 8'h02);
    tm(140);
    go(1'b1, 8'h64, 8'h00);
    chk({r1, r0}, 16'h02FF);
    tm(120);
    go(1'b1, 8'h63, 8'h00);
    chk({r1, r0}, 16'h003C);
  endtask
  task automatic t_fault();
    fork
      go(1'b0, 8'h07, 8'h5A);
      zap();
    join
    chk(r0, 8'h04);
    fork
      go(1'b1, 8'h07, 8'h00);
      zap();
    join
    chk(r1, 8'h04);
  endtask
  task automatic t_abort();
    bnv_cpu_model_i.wr(REG_ARG_ADDR, 32'h05, resp);
    bnv_cpu_model_i.wr(REG_ARG_DATA, 32'h99, resp);
    bnv_cpu_model_i.wr(REG_CALL, 32'h1, resp);
    repeat (100) @(posedge aclk);
    rst();
    go(1'b1, 8'h05, 8'h00);
    chk(r0, 8'hA5);
    chk(r1, 8'h10);
    go(1'b1, 8'h63, 8'h00);
    chk({r1, r0}, 16'h003C);
  endtask
  // Main sequence
  initial begin
    aresetn = 1'b0;
    flash_fault = 1'b0;
    // Flash timing is taken as set up before the first call
    rst();
    t_map();
    t_ops();
    t_bad();
    t_fault();
    t_abort();
    close_out();
  end
endmodule
